// ==== rtl/rsrb_defines.vh ====
// Purpose: constants for the radio status readback bank
// Assumes: 7-bit register address, 8-bit data
// Notes:   definitions only
`ifndef RSRB_DEFINES_VH
`define RSRB_DEFINES_VH

`define RSRB_ADDR_W            7
`define RSRB_DATA_W            8
`define RSRB_ADDR_INIT_DONE    7'h41
`define RSRB_ADDR_SIG_STRENGTH 7'h42
`define RSRB_ADDR_AVG_FREQ     7'h43
`define RSRB_ADDR_INST_FREQ    7'h44
`define RSRB_ADDR_CAL_PUMP     7'h45
`define RSRB_ADDR_REV_TUNE     7'h46
`define RSRB_ADDR_OSC_CAL      7'h47
`define RSRB_ADDR_CONV_SAMPLE  7'h48
`define RSRB_ADDR_FILT_I       7'h49
`define RSRB_ADDR_FILT_Q       7'h4a
`define RSRB_ADDR_GAIN_OFFSET  7'h4b
`define RSRB_ZERO8             8'h00
`define RSRB_ZERO1             1'h0
`define RSRB_ZERO3             3'h0
`define RSRB_REV_MAX           3'h1
`define RSRB_SYNC_W            60
`define RSRB_RAW_W             81
`define RSRB_NUM_REGS          11
`define RSRB_POS_INIT          73
`define RSRB_POS_SIGNAL_STRENGTH          66
`define RSRB_POS_AFC           58
`define RSRB_POS_INST          50
`define RSRB_POS_CAL           46
`define RSRB_POS_PUMP          42
`define RSRB_POS_TUNE          37
`define RSRB_POS_FCOMP         36
`define RSRB_POS_CCOMP         35
`define RSRB_POS_CCUR          29
`define RSRB_POS_MIX           27
`define RSRB_POS_CI            24
`define RSRB_POS_CQ            21
`define RSRB_POS_FILT_I        13
`define RSRB_POS_FILT_Q        5
`define RSRB_POS_GOFF          0

`endif

// ==== rtl/rsrb_status_bank.v ====
// Purpose: read-only status readback bank of a narrowband radio transceiver
// Assumes: sub-block inputs are asynchronous to clock; register port is same-clock
// Notes:   writes are accepted and ignored; reads have no side effect
// Functional notes
// - bits 7,6,5 flag converter, gain, shaping init
// - bits 4,3 flag freq-correct and bit-timing init
// - bits 2,1,0 flag synthesizer, sequencer, calibration init
// - signal strength top bit reads zero
// - signal strength low seven bits, 1.5 dB
// - register 43h gives signed decision level
// - register 44h gives signed instant offset
// - 45h holds calibration converter and pump
// - 46h top bits give revision, 0 or 1
// - 46h low bits give oscillator tuning array
// - 47h gives comparator bit7, cal current
// - 47h bit 6 is current comparator result
// - 48h gives mixer, I and Q converter
// - 49h, 4Ah give filter I and Q upper
// - 4Bh top three zero, gain offset low
// - signal strength and correction are read-only
// - init completion register at 41h, read-only
`timescale 1ns/100ps
`default_nettype none
`include "rsrb_defines.vh"

module rsrb_status_bank
#(
    parameter [2:0] REV_CODE = 3'h1 // arbitrary value, must stay 0 or 1
)
(
    input  wire        clock,                       // 20 MHz clock
    input  wire        rst_b,                       // synchronous reset, active low
    input  wire        clk_en,                      // freezes all state while low
    input  wire [6:0]  reg_addr,                    // register address
    input  wire [7:0]  reg_wdata,                   // write data, ignored
    input  wire        reg_wr,                      // write strobe, ignored
    input  wire        reg_rd,                      // read strobe
    output reg  [7:0]  reg_rdata_ff,                // read data, cycle after strobe
    input  wire        adc_init_flag,               // converter control reset done
    input  wire        gain_loop_init_flag,         // gain loop reset done
    input  wire        shaping_filter_init_flag,    // shaping filter reset done
    input  wire        freq_correct_init_flag,      // freq correction reset done
    input  wire        bit_timing_init_flag,        // modulator/bit sync reset done
    input  wire        synthesizer_init_flag,       // synthesizer reset done
    input  wire        powerup_sequencer_init_flag, // sequencer reset done
    input  wire        cal_lock_init_flag,          // calibration/lock reset done
    input  wire [6:0]  signal_strength_in,          // log power, 1.5 dB steps
    input  wire [7:0]  decision_level,              // signed demodulator level
    input  wire [7:0]  instant_offset_in,           // signed instantaneous offset
    input  wire [3:0]  cal_converter_value,         // applied calibration value
    input  wire [3:0]  charge_pump_setting,         // applied pump current
    input  wire [4:0]  oscillator_tuning_array,     // applied tuning array
    input  wire        phase_freq_comparator,       // phase detector comparator
    input  wire        osc_current_comparator,      // 1: reference above core current
    input  wire [5:0]  osc_cal_current_setting,     // applied cal current
    input  wire [1:0]  converter_mixer_in,          // mixer input to converter
    input  wire [2:0]  converter_i_out,             // in-phase converter output
    input  wire [2:0]  converter_q_out,             // quadrature converter output
    input  wire [7:0]  filter_i_upper,              // channel filter I upper bits
    input  wire [7:0]  filter_q_upper,              // channel filter Q upper bits
    input  wire [4:0]  gain_offset_in               // preset vs applied gain offset
);

    // field widths of the status inputs as they arrive
    localparam integer W_FLAGS  = 8;
    localparam integer W_SIGNAL_STRENGTH   = 7;
    localparam integer W_AFC    = 8;
    localparam integer W_INST   = 8;
    localparam integer W_CAL    = 4;
    localparam integer W_PUMP   = 4;
    localparam integer W_TUNE   = 5;
    localparam integer W_CCUR   = 6;
    localparam integer W_MIX    = 2;
    localparam integer W_CONV   = 3;
    localparam integer W_FILT   = 8;
    localparam integer W_GOFF   = 5;

    // bit of each register in the one-hot read select
    localparam integer SEL_INIT = 0;
    localparam integer SEL_SIGNAL_STRENGTH = 1;
    localparam integer SEL_AFC  = 2;
    localparam integer SEL_INST = 3;
    localparam integer SEL_CALP = 4;
    localparam integer SEL_REV  = 5;
    localparam integer SEL_OSC  = 6;
    localparam integer SEL_CONV = 7;
    localparam integer SEL_FI   = 8;
    localparam integer SEL_FQ   = 9;
    localparam integer SEL_GOFF = 10;

    // every status input side by side, in a fixed field order
    wire [`RSRB_RAW_W-1:0]    raw_bus;

    // second synchroniser stage, the only view logic may read
    wire [`RSRB_RAW_W-1:0]    sync2_q;

    // one-hot select of the register being read, zero when idle
    reg  [`RSRB_NUM_REGS-1:0] rd_sel;

    // revision code after the reserved-code clamp
    wire [2:0]                rev_code;

    // next read data, assembled from the synchronised view
    reg  [`RSRB_DATA_W-1:0]   nxt_rdata;

    // synchronised fields, named after what they report
    wire [W_FLAGS-1:0]        f_init;
    wire [W_SIGNAL_STRENGTH-1:0]         f_signal_strength;
    wire [W_AFC-1:0]          f_afc;
    wire [W_INST-1:0]         f_inst;

    wire [W_CAL-1:0]          f_cal;
    wire [W_PUMP-1:0]         f_pump;
    wire [W_TUNE-1:0]         f_tune;
    wire                      f_fcomp;
    wire                      f_ccomp;
    wire [W_CCUR-1:0]         f_ccur;
    wire [W_MIX-1:0]          f_mix;
    wire [W_CONV-1:0]         f_ci;
    wire [W_CONV-1:0]         f_cq;
    wire [W_FILT-1:0]         f_fi;
    wire [W_FILT-1:0]         f_fq;
    wire [W_GOFF-1:0]         f_goff;

    // register words as software sees them
    wire [`RSRB_DATA_W-1:0]   w_init;
    wire [`RSRB_DATA_W-1:0]   w_signal_strength;
    wire [`RSRB_DATA_W-1:0]   w_afc;
    wire [`RSRB_DATA_W-1:0]   w_inst;

    wire [`RSRB_DATA_W-1:0]   w_calp;
    wire [`RSRB_DATA_W-1:0]   w_rev;
    wire [`RSRB_DATA_W-1:0]   w_osc;
    wire [`RSRB_DATA_W-1:0]   w_conv;
    wire [`RSRB_DATA_W-1:0]   w_fi;
    wire [`RSRB_DATA_W-1:0]   w_fq;
    wire [`RSRB_DATA_W-1:0]   w_goff;

    // levels only: nothing here needs edge detection
    assign raw_bus = {adc_init_flag,
                      gain_loop_init_flag,
                      shaping_filter_init_flag,
                      freq_correct_init_flag,
                      bit_timing_init_flag,
                      synthesizer_init_flag,
                      powerup_sequencer_init_flag,
                      cal_lock_init_flag,
                      signal_strength_in,
                      decision_level,
                      instant_offset_in,
                      cal_converter_value,
                      charge_pump_setting,
                      oscillator_tuning_array,
                      phase_freq_comparator,
                      osc_current_comparator,
                      osc_cal_current_setting,
                      converter_mixer_in,
                      converter_i_out,
                      converter_q_out,
                      filter_i_upper,
                      filter_q_upper,
                      gain_offset_in};

    // multi-bit values may tear across a sample; acceptable for live diagnostics
    // a pair of flops per bit; only the second stage fans out
    genvar gi;

    generate
        for (gi = 0; gi < `RSRB_RAW_W; gi = gi + 1)
        begin : g_sync
            reg s1_ff;
            reg s2_ff;
            always @(posedge clock)
            begin
                if (!rst_b)
                begin
                    s1_ff <= 1'b0;
                    s2_ff <= 1'b0;
                end
                else if (clk_en)
                begin
                    s1_ff <= raw_bus[gi];
                    s2_ff <= s1_ff;
                end
            end
            assign sync2_q[gi] = s2_ff;
        end
    endgenerate

    // field slices; positions follow the raw_bus order above
    assign f_init  = sync2_q[`RSRB_POS_INIT +: W_FLAGS];
    assign f_signal_strength  = sync2_q[`RSRB_POS_SIGNAL_STRENGTH +: W_SIGNAL_STRENGTH];
    assign f_afc   = sync2_q[`RSRB_POS_AFC +: W_AFC];
    assign f_inst  = sync2_q[`RSRB_POS_INST +: W_INST];

    // test-only readouts
    assign f_cal   = sync2_q[`RSRB_POS_CAL +: W_CAL];
    assign f_pump  = sync2_q[`RSRB_POS_PUMP +: W_PUMP];
    assign f_tune  = sync2_q[`RSRB_POS_TUNE +: W_TUNE];
    assign f_fcomp = sync2_q[`RSRB_POS_FCOMP];
    assign f_ccomp = sync2_q[`RSRB_POS_CCOMP];
    assign f_ccur  = sync2_q[`RSRB_POS_CCUR +: W_CCUR];
    assign f_mix   = sync2_q[`RSRB_POS_MIX +: W_MIX];
    assign f_ci    = sync2_q[`RSRB_POS_CI +: W_CONV];
    assign f_cq    = sync2_q[`RSRB_POS_CQ +: W_CONV];
    assign f_fi    = sync2_q[`RSRB_POS_FILT_I +: W_FILT];
    assign f_fq    = sync2_q[`RSRB_POS_FILT_Q +: W_FILT];
    assign f_goff  = sync2_q[`RSRB_POS_GOFF +: W_GOFF];

    // words of the normal-use registers
    assign w_init  = f_init;
    assign w_signal_strength  = {`RSRB_ZERO1, f_signal_strength};
    assign w_afc   = f_afc;
    assign w_inst  = f_inst;

    // words of the test-only registers
    assign w_calp  = {f_cal, f_pump};
    assign w_rev   = {rev_code, f_tune};
    assign w_osc   = {f_fcomp, f_ccomp, f_ccur};
    assign w_conv  = {f_mix, f_ci, f_cq};
    assign w_fi    = f_fi;
    assign w_fq    = f_fq;
    assign w_goff  = {`RSRB_ZERO3, f_goff};

    // reserved revision codes must never be reported
    assign rev_code = (REV_CODE > `RSRB_REV_MAX) ? `RSRB_REV_MAX : REV_CODE;

    // address decode; unmapped addresses give an all-zero select
    function [`RSRB_NUM_REGS-1:0] addr_to_sel;
        input [`RSRB_ADDR_W-1:0] addr;
        begin
            addr_to_sel = {`RSRB_NUM_REGS{1'b0}};
            case (addr)
                `RSRB_ADDR_INIT_DONE:    addr_to_sel[SEL_INIT] = 1'b1;
                `RSRB_ADDR_SIG_STRENGTH: addr_to_sel[SEL_SIGNAL_STRENGTH] = 1'b1;
                `RSRB_ADDR_AVG_FREQ:     addr_to_sel[SEL_AFC]  = 1'b1;
                `RSRB_ADDR_INST_FREQ:    addr_to_sel[SEL_INST] = 1'b1;
                `RSRB_ADDR_CAL_PUMP:     addr_to_sel[SEL_CALP] = 1'b1;
                `RSRB_ADDR_REV_TUNE:     addr_to_sel[SEL_REV]  = 1'b1;
                `RSRB_ADDR_OSC_CAL:      addr_to_sel[SEL_OSC]  = 1'b1;
                `RSRB_ADDR_CONV_SAMPLE:  addr_to_sel[SEL_CONV] = 1'b1;
                `RSRB_ADDR_FILT_I:       addr_to_sel[SEL_FI]   = 1'b1;
                `RSRB_ADDR_FILT_Q:       addr_to_sel[SEL_FQ]   = 1'b1;
                `RSRB_ADDR_GAIN_OFFSET:  addr_to_sel[SEL_GOFF] = 1'b1;
                default:                 addr_to_sel = {`RSRB_NUM_REGS{1'b0}};
            endcase
        end
    endfunction

    // a write never selects anything: the bank holds no writable state
    always @*
    begin
        rd_sel = {`RSRB_NUM_REGS{1'b0}};
        if (reg_rd)
        begin
            rd_sel = addr_to_sel(reg_addr);
        end
    end

    // one-hot select, so at most one branch below applies
    always @*
    begin
        nxt_rdata = `RSRB_ZERO8;
        if (rd_sel[SEL_INIT])
        begin
            nxt_rdata = w_init;
        end

        if (rd_sel[SEL_SIGNAL_STRENGTH])
        begin
            nxt_rdata = w_signal_strength;
        end

        if (rd_sel[SEL_AFC])
        begin
            nxt_rdata = w_afc;
        end

        if (rd_sel[SEL_INST])
        begin
            nxt_rdata = w_inst;
        end

        if (rd_sel[SEL_CALP])
        begin
            nxt_rdata = w_calp;
        end

        if (rd_sel[SEL_REV])
        begin
            nxt_rdata = w_rev;
        end

        if (rd_sel[SEL_OSC])
        begin
            nxt_rdata = w_osc;
        end

        if (rd_sel[SEL_CONV])
        begin
            nxt_rdata = w_conv;
        end

        if (rd_sel[SEL_FI])
        begin
            nxt_rdata = w_fi;
        end

        if (rd_sel[SEL_FQ])
        begin
            nxt_rdata = w_fq;
        end

        if (rd_sel[SEL_GOFF])
        begin
            nxt_rdata = w_goff;
        end
    end

    // read data falls back to zero in the cycle after any non-read with clk_en high
    always @(posedge clock)
    begin
        if (!rst_b)
        begin
            reg_rdata_ff <= `RSRB_ZERO8;
        end
        else if (clk_en)
        begin
            reg_rdata_ff <= nxt_rdata;
        end
    end

endmodule // rsrb_status_bank
`default_nettype wire

// ==== dv/rsrb_status_chk.sv ====
// Purpose: port assertions for the status readback bank
// Assumes: reads taken with inputs steady three cycles
// Notes:   bound to every bank instance
`timescale 1ns/100ps
`default_nettype none
module rsrb_status_chk
(
    input wire logic       clock,              // bank clock
    input wire logic       rst_b,              // sync reset, active low
    input wire logic       clk_en,             // clock enable
    input wire logic [6:0] reg_addr,           // register address
    input wire logic       reg_rd,             // read strobe
    input wire logic [7:0] reg_rdata_ff,       // read data
    input wire logic [6:0] signal_strength_in, // strength input
    input wire logic [7:0] decision_level      // decision level input
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    wire rd_ok = reg_rd && clk_en;
    a_idle_zero: assert property (clk_en && !reg_rd |=> reg_rdata_ff == 8'h00)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (rd_ok && (reg_addr < 7'h41 || reg_addr > 7'h4b)
        |=> reg_rdata_ff == 8'h00) else $error("unmapped read not zero");
    a_strength_msb: assert property (rd_ok && reg_addr == 7'h42 |=> !reg_rdata_ff[7])
        else $error("strength top bit set");
    a_gain_top: assert property (rd_ok && reg_addr == 7'h4b |=> reg_rdata_ff[7:5] == 3'h0)
        else $error("gain offset top bits set");
    a_rev_legal: assert property (rd_ok && reg_addr == 7'h46 |=> reg_rdata_ff[7:5] <= 3'h1)
        else $error("reserved revision code");
    a_freeze_hold: assert property (!clk_en |=> $stable(reg_rdata_ff))
        else $error("read data moved while disabled");
    a_strength_live: assert property ((clk_en && $stable(signal_strength_in)) [*3] ##0
        (rd_ok && reg_addr == 7'h42) |=> reg_rdata_ff[6:0] == $past(signal_strength_in))
        else $error("strength read not live");
    a_avg_live: assert property ((clk_en && $stable(decision_level)) [*3] ##0
        (rd_ok && reg_addr == 7'h43) |=> reg_rdata_ff == $past(decision_level))
        else $error("decision level read not live");
endmodule // rsrb_status_chk
bind rsrb_status_bank rsrb_status_chk u_rsrb_status_chk (.clock, .rst_b, .clk_en, .reg_addr,
    .reg_rd, .reg_rdata_ff, .signal_strength_in, .decision_level);
`default_nettype wire

// ==== dv/rsrb_status_bank_tb_top.sv ====
// Purpose: self-checking bench for the status readback bank
// Assumes: status inputs settle three cycles before reads
// Notes:   neighbours 40h and 4Ch probe the unmapped space
`timescale 1ns/100ps
`default_nettype none
module rsrb_status_bank_tb_top;
    logic        clock = 1'b0, rst_b = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [6:0]  reg_addr = 7'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic [80:0] st = 81'h1_A5C3_96F0_1E2D_3C4B_5A69;
    wire  [7:0]  reg_rdata_ff;
    int          errors = 0, tests_run = 0, cyc = 0;
    rsrb_status_bank u_rsrb_status_bank (.clock, .rst_b, .clk_en, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata_ff, .adc_init_flag(st[80]), .gain_loop_init_flag(st[79]),
        .shaping_filter_init_flag(st[78]), .freq_correct_init_flag(st[77]),
        .bit_timing_init_flag(st[76]), .synthesizer_init_flag(st[75]),
        .powerup_sequencer_init_flag(st[74]), .cal_lock_init_flag(st[73]),
        .signal_strength_in(st[72:66]), .decision_level(st[65:58]),
        .instant_offset_in(st[57:50]), .cal_converter_value(st[49:46]),
        .charge_pump_setting(st[45:42]), .oscillator_tuning_array(st[41:37]),
        .phase_freq_comparator(st[36]), .osc_current_comparator(st[35]),
        .osc_cal_current_setting(st[34:29]), .converter_mixer_in(st[28:27]),
        .converter_i_out(st[26:24]), .converter_q_out(st[23:21]),
        .filter_i_upper(st[20:13]), .filter_q_upper(st[12:5]), .gain_offset_in(st[4:0]));
    initial forever #25 clock = ~clock;
    function automatic logic [7:0] expv(input logic [6:0] a);
        case (a)
            7'h41: expv = st[80:73];
            7'h42: expv = {1'b0, st[72:66]};
            7'h46: expv = {3'h1, st[41:37]};
            7'h4b: expv = {3'h0, st[4:0]};
            7'h43: expv = st[65:58];
            7'h44: expv = st[57:50];
            7'h45: expv = st[49:42];
            7'h47: expv = st[36:29];
            7'h48: expv = st[28:21];
            7'h49: expv = st[20:13];
            7'h4a: expv = st[12:5];
            default: expv = 8'h00;
        endcase
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [6:0] a);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), expv(a), reg_rdata_ff);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            errors++;
            give_verdict();
        end
    end
    initial
    begin
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        repeat (3) @(posedge clock);
        for (int a = 'h40; a <= 'h4c; a++) rd(7'(a));
        $display("test map done");
        for (int a = 'h41; a <= 'h4b; a++)
        begin
            @(posedge clock);
            reg_wr <= 1'b1;
            reg_addr <= 7'(a);
            reg_wdata <= ~expv(7'(a));
            @(posedge clock);
            reg_wr <= 1'b0;
            rd(7'(a));
            rd(7'(a));
        end
        $display("test write ignored done");
        @(posedge clock);
        st <= ~st;
        repeat (3) @(posedge clock);
        for (int a = 'h41; a <= 'h4b; a++) rd(7'(a));
        rd(7'h42);
        rd(7'h43);
        $display("test live update done");
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= 7'h42;
        @(posedge clock);
        reg_rd <= 1'b0;
        clk_en <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
        chk("frozen read", expv(7'h42), reg_rdata_ff);
        @(posedge clock);
        clk_en <= 1'b1;
        $display("test freeze done");
        give_verdict();
    end
endmodule // rsrb_status_bank_tb_top
`default_nettype wire
